// ==== core/tcb_pkg.sv ====
package tcb_pkg;
    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int RAM_AW = 8;
    localparam int RAM_DW = 32;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 32;
    localparam logic [7:0] SET_STRIDE = 8'h03;

    // ------------------------------------------------------------
    // Field positions in the register-set words
    // ------------------------------------------------------------
    localparam int MDA_SRC_LSB = 6;
    localparam int MDA_DST_LSB = 4;
    localparam int MDA_OP_LSB = 2;
    localparam int MDA_AREA_BIT = 1;
    localparam int MDA_WIDTH_BIT = 0;
    localparam int MDB_CHAIN_BIT = 7;
    localparam int MDB_IRQ_BIT = 6;
    localparam int WORD_TOP_LSB = 24;
    localparam int CNTA_LSB = 16;
    localparam logic [1:0] IDX_MODE_SRC = 2'h0;
    localparam logic [1:0] IDX_MODE_DST = 2'h1;
    localparam logic [1:0] IDX_COUNT = 2'h2;
    localparam logic [1:0] IDX_VECTOR = 2'h3;

    // ------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] OP_NORMAL = 2'h0;
    localparam logic [1:0] OP_REPEAT = 2'h1;
    localparam logic [1:0] OP_BLOCK = 2'h2;
    localparam logic [1:0] STEP_INC = 2'h2;
    localparam logic [1:0] STEP_DEC = 2'h3;
    localparam logic [23:0] RST_ADDR = 24'h00_0000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_VEC = 4'h1,
        ST_VWAIT = 4'h3,
        ST_RD = 4'h2,
        ST_RWAIT = 4'h6,
        ST_XRD = 4'h7,
        ST_XWR = 4'h5,
        ST_WB = 4'h4,
        ST_DONE = 4'hC
    } tcb_state_t;
endpackage : tcb_pkg

// ==== core/tcb_stream_if.sv ====
`timescale 1ns/1ps
interface tcb_stream_if #(parameter int W = 16);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport prod (output valid, output data, input ready);
    modport cons (input valid, input data, output ready);
endinterface : tcb_stream_if

// ==== core/tcb_fifo.sv ====
`timescale 1ns/1ps
module tcb_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input logic clk_sys,
    input logic rst_n,
    // Streams
    tcb_stream_if.cons wr,
    tcb_stream_if.prod rd
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gBadDepth
        $error("tcb_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [W-1:0] mem [DEPTH];
    logic [PW:0] wrPtr_q;
    logic [PW:0] rdPtr_q;
    wire fifoEmpty = (wrPtr_q == rdPtr_q);
    wire fifoFull = (wrPtr_q[PW-1:0] == rdPtr_q[PW-1:0]) && (wrPtr_q[PW] != rdPtr_q[PW]);
    wire doPush = wr.valid && !fifoFull;
    wire doPop = rd.ready && !fifoEmpty;

    assign wr.ready = !fifoFull;
    assign rd.valid = !fifoEmpty;
    assign rd.data = mem[rdPtr_q[PW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (doPush) begin
            mem[wrPtr_q[PW-1:0]] <= wr.data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_q + (PW + 1)'(doPush);
            rdPtr_q <= rdPtr_q + (PW + 1)'(doPop);
        end
    end
endmodule : tcb_fifo

// ==== core/tcb_top.sv ====
// Behaviour
// - Arbiter acknowledges a requester; with several, only the highest priority one.
// - An acknowledged master owns the bus until the acknowledge is withdrawn.
// - CPU is lowest priority; a controller request moves the bus away from it.
// - Bus leaves the CPU only between bus cycles, never inside a split access.
// - Read-modify-write of bit instructions keeps the bus with the CPU throughout.
// - While the CPU sleeps, a controller request is granted at once.
// - Controller raises its bus request whenever an activation becomes pending.
// - Controller releases only when idle with no activation pending, after the set write-back.
// - Reset puts bus logic into reset at once, abandoning any bus cycle.
// - Controller starts from an enabled interrupt source or from software.
// - Register-set RAM of 1 kbyte reached over 32 bits, one word per state.
// - Each activation loads a set, transfers, then writes the updated set back.
// - Working registers have no CPU path; only their RAM copies are visible.
// - Source pointer: 0X fixed, 10 adds 1 or 2, 11 subtracts 1 or 2.
// - Destination pointer: 0X fixed, 10 adds 1 or 2, 11 subtracts 1 or 2.
// - Operation kind 00 normal, 01 repeat, 10 block; 11 is never programmed.
// - Area select 0 makes destination the repeat/block area, 1 the source.
// - Unit width 0 is byte, 1 is word, and sets the pointer step.
// - Pointers and bus address carry 24 bits for a 16-Mbyte space.
// - One activation may run several register sets in succession by chaining.
// - Normal operation decrements the 16-bit count and ends at zero.
// - Chain enabled skips end check and both clears, then takes the next set.
// - Interrupt select 1 interrupts after each transfer, 0 only at the end.
`timescale 1ns/1ps
module tcb_top (
    // Clock and reset
    input logic clk_sys,
    input logic rst_n,
    // Activation
    input logic intActReq,
    input logic [tcb_pkg::RAM_AW-1:0] intVector,
    input logic swActReq,
    input logic [tcb_pkg::RAM_AW-1:0] swVector,
    // CPU side of the arbiter
    input logic cpuBusReq,
    input logic cpuBoundary,
    input logic cpuRmwLock,
    input logic cpuSleep,
    output logic cpuAck,
    // Register-set RAM
    output logic [tcb_pkg::RAM_AW-1:0] ramAddr,
    output logic ramWe,
    output logic [tcb_pkg::RAM_DW-1:0] ramWdata,
    input logic [tcb_pkg::RAM_DW-1:0] ramRdata,
    // System bus master
    output logic tcGrant,
    output logic [tcb_pkg::ADDR_W-1:0] busAddr,
    output logic busRd,
    output logic busWr,
    output logic busWord,
    output logic [tcb_pkg::DATA_W-1:0] busWdata,
    input logic [tcb_pkg::DATA_W-1:0] busRdata,
    input logic busDone,
    // Completion
    output logic cpuIrq,
    output logic srcClear,
    output logic enClear,
    output logic actSoft,
    output logic tcBusy
);
    import tcb_pkg::*;

    // ------------------------------------------------------------
    // Pointer helpers
    // ------------------------------------------------------------
    function automatic logic [23:0] stepAddr(input logic [23:0] a, input logic [1:0] m, input logic w);
        logic [23:0] s;
        s = w ? 24'h00_0002 : 24'h00_0001;
        if (m == STEP_INC) begin
            return a + s;
        end else if (m == STEP_DEC) begin
            return a - s;
        end
        return a;
    endfunction : stepAddr

    function automatic logic [23:0] areaBack(input logic [23:0] a, input logic [1:0] m, input logic [7:0] n,
                                             input logic w);
        logic [8:0] len;
        logic [23:0] span;
        len = (n == 8'h00) ? 9'h100 : {1'b0, n};
        span = w ? {14'h0000, len, 1'b0} : {15'h0000, len};
        if (m == STEP_INC) begin
            return a - span;
        end else if (m == STEP_DEC) begin
            return a + span;
        end
        return a;
    endfunction : areaBack

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    tcb_state_t st_q;
    logic intPend_q, swPend_q, soft_q;
    logic [RAM_AW-1:0] intVec_q, swVec_q, vec_q, base_q;
    logic tcBusReq_q, tcGrant_q, cpuAck_q;
    logic [1:0] rdIdx_q, wbIdx_q;
    logic tag1V_q, tag2V_q;
    logic [1:0] tag1I_q, tag2I_q;
    logic [7:0] mdA_q, mdB_q;
    logic [23:0] src_q, dst_q;
    logic [15:0] cntA_q, cntB_q;
    logic endHit_q;
    logic [RAM_AW-1:0] ramAddr_q;
    logic ramWe_q;
    logic [31:0] ramWdata_q;
    logic [23:0] busAddr_q;
    logic busRd_q, busWr_q, busWord_q;
    logic [15:0] busWdata_q;
    logic cpuIrq_q, srcClear_q, enClear_q;

    // ------------------------------------------------------------
    // Data FIFO between bus read and bus write
    // ------------------------------------------------------------
    tcb_stream_if #(.W(DATA_W)) inS ();
    tcb_stream_if #(.W(DATA_W)) outS ();

    tcb_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) uFifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr(inS),
        .rd(outS)
    );

    assign inS.valid = (st_q == ST_XRD) && busRd_q && busDone;
    assign inS.data = busRdata;
    assign outS.ready = (st_q == ST_XWR) && !busWr_q;

    // ------------------------------------------------------------
    // Decode of the working registers
    // ------------------------------------------------------------
    wire [1:0] srcMode = mdA_q[MDA_SRC_LSB+:2];
    wire [1:0] dstMode = mdA_q[MDA_DST_LSB+:2];
    wire [1:0] opKind = mdA_q[MDA_OP_LSB+:2];
    wire areaSrc = mdA_q[MDA_AREA_BIT];
    wire unitWord = mdA_q[MDA_WIDTH_BIT];
    wire chainOn = mdB_q[MDB_CHAIN_BIT];
    wire irqEach = mdB_q[MDB_IRQ_BIT];
    wire isNormal = (opKind == OP_NORMAL);
    wire isBlock = (opKind == OP_BLOCK);
    wire [23:0] srcStep = stepAddr(src_q, srcMode, unitWord);
    wire [23:0] dstStep = stepAddr(dst_q, dstMode, unitWord);
    wire [7:0] cntLoDec = cntA_q[7:0] - 8'h01;
    wire wrapArea = !isNormal && (cntLoDec == 8'h00);
    wire [15:0] cntANext = isNormal ? cntA_q - 16'h0001 :
                           wrapArea ? {cntA_q[15:8], cntA_q[15:8]} : {cntA_q[15:8], cntLoDec};
    wire [15:0] cntBNext = (isBlock && wrapArea) ? cntB_q - 16'h0001 : cntB_q;
    wire [23:0] srcNext = (wrapArea && areaSrc) ? areaBack(srcStep, srcMode, cntA_q[15:8], unitWord) : srcStep;
    wire [23:0] dstNext = (wrapArea && !areaSrc) ? areaBack(dstStep, dstMode, cntA_q[15:8], unitWord) : dstStep;
    wire endHit = isNormal ? (cntANext == 16'h0000) : (isBlock && wrapArea && cntBNext == 16'h0000);
    wire moreBlock = isBlock && !wrapArea;
    wire xferDone = (st_q == ST_XWR) && busWr_q && busDone;
    wire finishAct = endHit_q || irqEach;
    wire anyPend = intPend_q || swPend_q;
    wire [RAM_AW-1:0] wbAddr = base_q + {6'h00, wbIdx_q};
    wire [31:0] wbWord = (wbIdx_q == IDX_MODE_SRC) ? {mdA_q, src_q} :
                         (wbIdx_q == IDX_MODE_DST) ? {mdB_q, dst_q} : {cntA_q, cntB_q};

    // ------------------------------------------------------------
    // Arbiter
    // ------------------------------------------------------------
    wire cpuMayYield = cpuSleep || (cpuBoundary && !cpuRmwLock);
    wire tcTake = tcBusReq_q && !tcGrant_q && cpuMayYield;
    wire tcRelease = tcGrant_q && (st_q == ST_IDLE) && !anyPend;
    wire tcGrant_d = tcTake || (tcGrant_q && !tcRelease);
    wire cpuAck_d = cpuBusReq && !tcGrant_d;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tcGrant_q <= 1'b0;
            cpuAck_q <= 1'b0;
            tcBusReq_q <= 1'b0;
        end else begin
            tcGrant_q <= tcGrant_d;
            cpuAck_q <= cpuAck_d;
            tcBusReq_q <= anyPend || intActReq || swActReq || (st_q != ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Activation requests; a new request beats the clear on start
    // ------------------------------------------------------------
    wire startAct = (st_q == ST_IDLE) && tcGrant_q && anyPend;
    wire takeInt = startAct && intPend_q;
    wire takeSw = startAct && !intPend_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            intPend_q <= 1'b0;
            swPend_q <= 1'b0;
            intVec_q <= '0;
            swVec_q <= '0;
        end else begin
            intPend_q <= intActReq || (intPend_q && !takeInt);
            swPend_q <= swActReq || (swPend_q && !takeSw);
            if (intActReq) begin
                intVec_q <= intVector;
            end
            if (swActReq) begin
                swVec_q <= swVector;
            end
        end
    end

    // ------------------------------------------------------------
    // RAM read pipeline: address out, data two edges later
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tag1V_q <= 1'b0;
            tag2V_q <= 1'b0;
            tag1I_q <= 2'h0;
            tag2I_q <= 2'h0;
        end else begin
            tag1V_q <= (st_q == ST_VEC) || (st_q == ST_RD);
            tag1I_q <= (st_q == ST_VEC) ? IDX_VECTOR : rdIdx_q;
            tag2V_q <= tag1V_q;
            tag2I_q <= tag1I_q;
        end
    end

    // Working registers are filled only from RAM
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mdA_q <= '0;
            mdB_q <= '0;
            src_q <= RST_ADDR;
            dst_q <= RST_ADDR;
            cntA_q <= '0;
            cntB_q <= '0;
        end else if (tag2V_q && tag2I_q == IDX_MODE_SRC) begin
            {mdA_q, src_q} <= ramRdata;
        end else if (tag2V_q && tag2I_q == IDX_MODE_DST) begin
            {mdB_q, dst_q} <= ramRdata;
        end else if (tag2V_q && tag2I_q == IDX_COUNT) begin
            {cntA_q, cntB_q} <= ramRdata;
        end else if (xferDone) begin
            src_q <= srcNext;
            dst_q <= dstNext;
            cntA_q <= cntANext;
            cntB_q <= cntBNext;
        end
    end

    // ------------------------------------------------------------
    // Controller sequence
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            busRd_q <= 1'b0;
            busWr_q <= 1'b0;
            ramWe_q <= 1'b0;
            vec_q <= '0;
            base_q <= '0;
            soft_q <= 1'b0;
            rdIdx_q <= 2'h0;
            wbIdx_q <= 2'h0;
            endHit_q <= 1'b0;
            ramAddr_q <= '0;
            ramWdata_q <= RST_WORD;
            busAddr_q <= RST_ADDR;
            busWord_q <= 1'b0;
            busWdata_q <= '0;
            cpuIrq_q <= 1'b0;
            srcClear_q <= 1'b0;
            enClear_q <= 1'b0;
        end else begin
            ramWe_q <= 1'b0;
            cpuIrq_q <= 1'b0;
            srcClear_q <= 1'b0;
            enClear_q <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (startAct) begin
                        vec_q <= intPend_q ? intVec_q : swVec_q;
                        soft_q <= !intPend_q;
                        st_q <= ST_VEC;
                    end
                end
                ST_VEC: begin
                    ramAddr_q <= vec_q;
                    st_q <= ST_VWAIT;
                end
                ST_VWAIT: begin
                    if (tag2V_q && tag2I_q == IDX_VECTOR) begin
                        base_q <= ramRdata[RAM_AW-1:0];
                        rdIdx_q <= 2'h0;
                        st_q <= ST_RD;
                    end
                end
                ST_RD: begin
                    ramAddr_q <= base_q + {6'h00, rdIdx_q};
                    rdIdx_q <= rdIdx_q + 2'h1;
                    if (rdIdx_q == IDX_COUNT) begin
                        st_q <= ST_RWAIT;
                    end
                end
                ST_RWAIT: begin
                    if (tag2V_q && tag2I_q == IDX_COUNT) begin
                        st_q <= ST_XRD;
                    end
                end
                ST_XRD: begin
                    if (!busRd_q && inS.ready) begin
                        busRd_q <= 1'b1;
                        busAddr_q <= src_q;
                        busWord_q <= unitWord;
                    end else if (busRd_q && busDone) begin
                        busRd_q <= 1'b0;
                        st_q <= ST_XWR;
                    end
                end
                ST_XWR: begin
                    if (!busWr_q && outS.valid) begin
                        busWr_q <= 1'b1;
                        busAddr_q <= dst_q;
                        busWdata_q <= outS.data;
                    end else if (xferDone) begin
                        busWr_q <= 1'b0;
                        endHit_q <= endHit;
                        wbIdx_q <= 2'h0;
                        st_q <= moreBlock ? ST_XRD : ST_WB;
                    end
                end
                ST_WB: begin
                    ramWe_q <= 1'b1;
                    ramAddr_q <= wbAddr;
                    ramWdata_q <= wbWord;
                    wbIdx_q <= wbIdx_q + 2'h1;
                    if (wbIdx_q == IDX_COUNT) begin
                        st_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (chainOn) begin
                        base_q <= base_q + SET_STRIDE;
                        rdIdx_q <= 2'h0;
                        st_q <= ST_RD;
                    end else begin
                        cpuIrq_q <= finishAct;
                        enClear_q <= finishAct;
                        srcClear_q <= !finishAct;
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cpuAck = cpuAck_q;
    assign tcGrant = tcGrant_q;
    assign ramAddr = ramAddr_q;
    assign ramWe = ramWe_q;
    assign ramWdata = ramWdata_q;
    assign busAddr = busAddr_q;
    assign busRd = busRd_q;
    assign busWr = busWr_q;
    assign busWord = busWord_q;
    assign busWdata = busWdata_q;
    assign cpuIrq = cpuIrq_q;
    assign srcClear = srcClear_q;
    assign enClear = enClear_q;
    assign actSoft = soft_q;
    assign tcBusy = tcBusReq_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    grant_excl_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(cpuAck_q && tcGrant_q)) else $error("both masters acknowledged");
    yield_point_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(tcGrant_q) |-> $past(cpuSleep || (cpuBoundary && !cpuRmwLock)))
        else $error("bus taken from cpu mid cycle");
    rmw_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cpuRmwLock && !cpuSleep && !tcGrant_q) |=> !tcGrant_q) else $error("bus taken during rmw");
    sleep_grant_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cpuSleep && tcBusReq_q && !tcGrant_q) |=> tcGrant_q) else $error("sleeping cpu kept bus");
    hold_grant_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (tcGrant_q && st_q != ST_IDLE) |=> tcGrant_q) else $error("grant dropped mid activation");
    req_raise_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (intActReq || swActReq) |=> tcBusReq_q) else $error("request not raised");
    wb_burst_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(ramWe_q) |-> ramWe_q [*3] ##1 !ramWe_q) else $error("write-back not three words");
    count_dec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (xferDone && isNormal) |=> cntA_q == $past(cntA_q) - 16'h0001) else $error("count not decremented");
    chain_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_q == ST_DONE && chainOn) |=> !(cpuIrq_q || enClear_q || srcClear_q))
        else $error("chained set raised a pulse");
    src_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (xferDone && isNormal && srcMode == STEP_INC && unitWord) |=> src_q == $past(src_q) + 24'h00_0002)
        else $error("source step wrong");
    reset_abort_a: assert property (@(posedge clk_sys) disable iff (1'b0)
        !rst_n |=> (!busRd_q && !busWr_q && st_q == ST_IDLE && !tcGrant_q)) else $error("reset did not abort");
endmodule : tcb_top

// ==== verification/tcb_partner.sv ====
`timescale 1ns/1ps
// ----
// Register-set RAM and bus slave
// ----
module tcb_partner (
    // Clock and pacing
    input logic clk_sys,
    input logic [1:0] slow,
    // Register-set RAM
    input logic [7:0] ramAddr,
    input logic ramWe,
    input logic [31:0] ramWdata,
    output logic [31:0] ramRdata = 32'h0000_0000,
    // System bus
    input logic [23:0] busAddr,
    input logic busRd,
    input logic busWr,
    input logic [15:0] busWdata,
    output logic [15:0] busRdata = 16'h0000,
    output logic busDone = 1'b0
);
    logic [31:0] ram [256];
    logic [15:0] mem [int];
    logic [1:0] waitCnt = 2'h0;
    always @(posedge clk_sys) begin
        if (ramWe) ram[ramAddr] <= ramWdata;
        ramRdata <= ram[ramAddr];
        busDone <= 1'b0;
        busRdata <= ~busRdata;
        if ((busRd || busWr) && !busDone) begin
            waitCnt <= waitCnt + 2'h1;
            if (waitCnt >= slow) begin
                busDone <= 1'b1;
                waitCnt <= 2'h0;
                busRdata <= mem[busAddr];
                if (busWr) mem[busAddr] = busWdata;
            end
        end
    end
endmodule : tcb_partner

// ==== verification/tcb_top_test.sv ====
`timescale 1ns/1ps
// ----
// Bench
// ----
module tcb_top_test;
    import tcb_pkg::*;
    logic clk_sys = 0, rst_n = 0, intActReq = 0, swActReq = 0, cpuBusReq = 1;
    logic cpuBoundary = 1, cpuRmwLock = 0, cpuSleep = 0, w = 0;
    logic cpuAck, ramWe, tcGrant, busRd, busWr, busWord, busDone, cpuIrq, srcClear, enClear, actSoft, tcBusy;
    logic [1:0] slow = 0;
    logic [7:0] vec = 8'h40, base, ramAddr;
    logic [15:0] busWdata, busRdata, left, d, expDat[$];
    logic [31:0] ramWdata, ramRdata;
    logic [23:0] busAddr, src, dst, expRd[$], expWr[$];
    logic [7:0] maT[5] = '{8'hB1, 8'h60, 8'hC1, 8'h20, 8'hA8}, mbT[5] = '{8'h00, 8'h40, 8'h00, 8'h40, 8'h80};
    int n_fail = 0, num_checks = 0, seed = 88, nIrq = 0, nSrc = 0, nEn = 0, fin;
    always #2.5 clk_sys = ~clk_sys;
    tcb_top DUT (.clk_sys, .rst_n, .intActReq, .intVector(vec), .swActReq, .swVector(vec), .cpuBusReq,
        .cpuBoundary, .cpuRmwLock, .cpuSleep, .cpuAck, .ramAddr, .ramWe, .ramWdata, .ramRdata, .tcGrant,
        .busAddr, .busRd, .busWr, .busWord, .busWdata, .busRdata, .busDone, .cpuIrq, .srcClear, .enClear,
        .actSoft, .tcBusy);
    tcb_partner P (.clk_sys, .slow, .ramAddr, .ramWe, .ramWdata, .ramRdata, .busAddr, .busRd, .busWr,
        .busWdata, .busRdata, .busDone);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task end_sim;
        if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    function automatic logic [23:0] nxt(logic [23:0] a, logic [1:0] m, logic wd);
        return m[1] ? (m[0] ? a - (wd ? 2 : 1) : a + (wd ? 2 : 1)) : a;
    endfunction : nxt
    always @(posedge clk_sys) begin
        nIrq += cpuIrq;
        nSrc += srcClear;
        nEn += enClear;
        if (busDone && busRd) begin
            chk(busAddr, expRd.pop_front());
            chk(busWord, w);
        end
        if (busDone && busWr) chk(busAddr, expWr.pop_front());
        if (busDone && busWr && w) chk(busWdata, expDat.pop_front());
        if (busRd || busWr || cpuAck) chk(tcGrant, !cpuAck);
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1;
        for (int k = 0; k < 5; k++) begin
            base = 8'h10 + 8'(k * 4);
            w = maT[k][0];
            left = 16'(k % 3 ? 1 : 2);
            src = 24'($random(seed)) & 24'hFF_FFFE;
            dst = 24'($random(seed)) & 24'hFF_FFFE;
            P.ram[vec] = {24'h00_0000, base};
            P.ram[base] = {maT[k], src};
            P.ram[base + 1] = {mbT[k], dst};
            P.ram[base + 2] = k == 4 ? {16'h0101, left} : {left, 16'h0001};
            // Second set, reached only by chaining from a block set
            P.ram[base + 3] = {8'h00, src};
            P.ram[base + 4] = {8'h00, dst};
            P.ram[base + 5] = {left, 16'h0001};
            while (left != 0) begin
                d = 16'($random(seed));
                P.mem[src] = d;
                expRd.push_back(src);
                expWr.push_back(dst);
                if (w) expDat.push_back(d);
                if (k == 4) begin
                    expRd.push_back(src);
                    expWr.push_back(dst);
                end
                fin = (left == 1) || mbT[k][6];
                nIrq = 0;
                nSrc = 0;
                nEn = 0;
                @(posedge clk_sys);
                slow <= 2'($random(seed));
                cpuRmwLock <= k == 1;
                cpuBoundary <= k < 2 || k == 4;
                cpuSleep <= k == 2;
                intActReq <= k[0];
                swActReq <= !k[0];
                @(posedge clk_sys);
                intActReq <= 0;
                swActReq <= 0;
                @(posedge clk_sys);
                #1;
                chk(tcBusy, 1);
                chk(tcGrant, !k[0]);
                repeat (4) @(posedge clk_sys);
                #1;
                chk(tcGrant, !k[0]);
                @(posedge clk_sys);
                cpuRmwLock <= 0;
                cpuBoundary <= 1;
                for (int t = 0; t < 300 && tcBusy !== 0; t++) @(posedge clk_sys);
                repeat (3) @(posedge clk_sys);
                #1;
                left = left - 1;
                src = nxt(src, maT[k][7:6], w);
                dst = k == 4 ? dst : nxt(dst, maT[k][5:4], w);
                chk(nIrq, fin);
                chk(nEn, fin);
                chk(nSrc, !fin);
                chk(P.ram[base], {maT[k], src});
                chk(P.ram[base + 1], {mbT[k], dst});
                chk(P.ram[base + 2], k == 4 ? {16'h0101, left} : {left, 16'h0001});
                if (k == 4) chk(P.ram[base + 5], {left, 16'h0001});
                chk(cpuAck, 1);
                chk(actSoft, !k[0]);
            end
        end
        @(posedge clk_sys);
        slow <= 2'h3;
        swActReq <= 1;
        @(posedge clk_sys);
        swActReq <= 0;
        for (int t = 0; t < 50 && busRd !== 1; t++) @(posedge clk_sys);
        rst_n <= 0;
        @(posedge clk_sys);
        #1;
        chk({busRd, tcGrant, tcBusy}, 0);
        end_sim();
    end
    initial begin
        #100000;
        n_fail++;
        end_sim();
    end
endmodule : tcb_top_test
